// File: sim/mcx_mem_model.sv
/*
 Program and data memory model that faces the core.
 Assumes the core registers its addresses; reads answer within that cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module mcx_mem_model (
	input  wire logic        i_clk,
	input  wire logic [11:0] i_pc_addr,
	output logic [7:0]       o_pc_data,
	input  wire logic [7:0]  i_dm_addr,
	input  wire logic        i_dm_we,
	input  wire logic [7:0]  i_dm_wdata,
	output logic [7:0]       o_dm_rdata
);
	logic [7:0] prog [0:4095];
	logic [7:0] ram  [0:255];

	// ==========================================================
	// Reads follow the registered address; a write lands on the next edge
	assign o_pc_data  = prog[i_pc_addr];
	assign o_dm_rdata = ram[i_dm_addr];

	always @(posedge i_clk) begin
		if (i_dm_we === 1'b1) begin
			ram[i_dm_addr] <= i_dm_wdata;
		end
	end
endmodule // mcx_mem_model

`default_nettype wire

// File: sim/testbench.sv
/*
 Self-checking bench for the core: small programs run from the memory model.
 Assumes the core's opcode grouping by low nibble and a zero-latency memory.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import mcx_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rst_b = 1'b0;
	logic        i_wdg_sel = 1'b0;
	logic        i_wake = 1'b0;
	logic [11:0] pc_addr;
	logic [7:0]  pc_data, dm_addr, dm_wdata, dm_rdata, acc;
	logic        dm_we, zero, carry, waiting, stopped;
	int          n_mismatch = 0;
	int          tests_run = 0;
	int          cycles = 0;
	logic [31:0] lfsr_q = 32'h9582_595e;
	logic [7:0]  prg [$];
	logic [3:0]  ops [4] = '{ALU_ADD_IMMEDIATE_VALUE, ALU_DIFFERENCE_IMMEDIATE, ALU_MASK_IMMEDIATE, ALU_CPI};
	logic [2:0]  conds [4] = '{CND_NZ, CND_NC, CND_Z, CND_C};
	logic [2:0]  bits [4] = '{3'h0, 3'h2, 3'h5, 3'h7};

	always #5 i_clk = ~i_clk;

	mcx_core dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wdg_sel(i_wdg_sel), .i_wake(i_wake),
		.o_pc_addr(pc_addr), .i_pc_data(pc_data), .o_dm_addr(dm_addr), .o_dm_we(dm_we),
		.o_dm_wdata(dm_wdata), .i_dm_rdata(dm_rdata), .o_acc(acc), .o_zero(zero),
		.o_carry(carry), .o_waiting(waiting), .o_stopped(stopped));
	mcx_mem_model mem_u (.i_clk(i_clk), .i_pc_addr(pc_addr), .o_pc_data(pc_data),
		.i_dm_addr(dm_addr), .i_dm_we(dm_we), .i_dm_wdata(dm_wdata), .o_dm_rdata(dm_rdata));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Returns {carry, zero, acc}; carry of a subtract is the borrow
	function automatic logic [9:0] alu(input logic [3:0] op, input logic [7:0] a,
		input logic [7:0] b);
		logic [8:0] s;
		case (op)
			ALU_ADD_IMMEDIATE_VALUE: s = {1'b0, a} + {1'b0, b};
			ALU_MASK_IMMEDIATE: s = {1'b0, a & b};
			default:  s = {1'b0, a} - {1'b0, b};
		endcase
		return {s[8], s[7:0] == 8'h00, (op == ALU_CPI) ? a : s[7:0]};
	endfunction

	task automatic stop_test();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rst();
		@(posedge i_clk);
		#1 i_rst_b = 1'b0;
		repeat (6) @(posedge i_clk);
		#1;
	endtask

	task automatic ld(input logic [11:0] a);
		foreach (prg[k]) mem_u.prog[a + 12'(k)] = prg[k];
	endtask

	// Runs until the closing jump-to-self has been fetched twice
	task automatic go(input logic [11:0] fin);
		int k;
		int hits;
		logic prev;
		hits = 0;
		prev = 1'b0;
		i_rst_b = 1'b1;
		for (k = 0; k < 400 && hits < 2; k++) begin
			@(posedge i_clk);
			#1;
			if (pc_addr === fin && !prev) hits++;
			prev = (pc_addr === fin);
		end
		chk(8'(hits), 8'h02);
	endtask

	always @(posedge i_clk) begin
		cycles = cycles + 1;
		if (cycles == 10000) begin
			n_mismatch = n_mismatch + 1;
			stop_test();
		end
	end

	// ==========================================================
	// Scenarios
	initial begin
		int i;
		logic [7:0] a, b, r;
		logic [9:0] e;
		logic [3:0] op;
		logic s, tk;
		for (i = 0; i < 24; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			a = lfsr_q[7:0];
			b = (i < 4) ? a : lfsr_q[15:8];
			op = ops[i % 4];
			rst();
			prg = '{{ALU_LDI, LO_IND}, a, {op, LO_IND}, b, {4'h0, INH_JP}, 8'h04};
			ld(12'h000);
			go(12'h004);
			e = alu(op, a, b);
			chk(acc, e[7:0]);
			chk(8'(zero), 8'(e[8]));
			if (op != ALU_MASK_IMMEDIATE) chk(8'(carry), 8'(e[9]));
		end
		for (i = 0; i < 6; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			a = (i == 0) ? 8'h80 : lfsr_q[7:0];
			op = (i % 3 == 0) ? INH_RLC : (i % 3 == 1) ? INH_SLA : INH_COM;
			rst();
			prg = '{{ALU_LDI, LO_IND}, a, {op, LO_INH}, {4'h0, INH_JP}, 8'h03};
			ld(12'h000);
			go(12'h003);
			e = (op == INH_COM) ? {2'b00, ~a} : {1'b0, a, 1'b0};
			chk(acc, e[7:0]);
			chk(8'(zero), 8'(e[7:0] == 8'h00));
			if (op != INH_COM) chk(8'(carry), 8'(e[8]));
		end
		// Carry survives a load, increment and immediate store
		rst();
		prg = '{8'h17, 8'hFF, 8'h57, 8'h01, 8'h1D, 8'h80, 8'hFE, 8'h15, 8'h35,
			8'h1D, 8'hC7, 8'h5A, 8'h09, 8'h0C};
		ld(12'h000);
		go(12'h00C);
		chk(acc, 8'hFF);
		chk(8'(carry), 8'h01);
		chk(8'(zero), 8'h00);
		chk(mem_u.ram[8'h80], 8'hFF);
		chk(mem_u.ram[8'hC7], 8'h5A);
		// Indirect through the first index register
		rst();
		prg = '{8'h1D, 8'h80, 8'h50, 8'h1D, 8'h50, 8'h9C, 8'h07, 8'h57, 8'h01, 8'h87,
			8'h09, 8'h0A};
		ld(12'h000);
		go(12'h00A);
		chk(mem_u.ram[8'h50], 8'h9D);
		for (i = 0; i < 4; i++) begin
			rst();
			prg = '{8'h17, 8'h00, {4'h2, 1'b0, conds[i]}, 8'h17, 8'hAA, 8'h09, 8'h05};
			ld(12'h000);
			go(12'h005);
			tk = (conds[i] == CND_NC) || (conds[i] == CND_Z);
			chk(acc, tk ? 8'h00 : 8'hAA);
		end
		rst();
		prg = '{8'h17, 8'h00, 8'h09, 8'h10};
		ld(12'h000);
		prg = '{8'h09, 8'h0D, 8'h00, 8'h3C};
		ld(12'h00D);
		go(12'h00D);
		// Bit ops only on plain data bytes, never on port registers
		for (i = 0; i < 8; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			r = lfsr_q[7:0];
			s = i[0];
			mem_u.ram[8'h40] = r;
			mem_u.ram[8'h41] = r;
			rst();
			prg = '{8'h17, 8'h00, {bits[i / 2], s, LO_BDIR}, 8'h41,
				{bits[i / 2], s, LO_BT}, 8'h40, 8'h03, 8'h17, 8'hAA, 8'h09, 8'h09};
			ld(12'h000);
			go(12'h009);
			tk = (r[bits[i / 2]] == s);
			a = r;
			a[bits[i / 2]] = s;
			chk(mem_u.ram[8'h41], a);
			chk(acc, tk ? 8'h00 : 8'hAA);
			chk(8'(carry), 8'(r[bits[i / 2]]));
			if (tk) chk(8'(zero), 8'h01);
		end
		rst();
		prg = '{8'h39, 8'hA5};
		ld(12'h000);
		prg = '{8'h21, 8'h10, 8'h57, 8'h01, 8'h39, 8'hA9};
		ld(12'h3A5);
		prg = '{8'h17, 8'h33, {INH_RET, LO_INH}};
		ld(12'h210);
		go(12'h3A9);
		chk(acc, 8'h34);
		for (i = 0; i < 3; i++) begin
			rst();
			i_wdg_sel = (i == 1);
			prg = '{(i == 2) ? 8'hED : 8'h6D, 8'h17, 8'h77, 8'h09, 8'h03};
			ld(12'h000);
			i_rst_b = 1'b1;
			for (int k = 0; k < 60 && waiting !== 1'b1 && stopped !== 1'b1; k++) begin
				@(posedge i_clk);
				#1;
			end
			chk(8'(stopped), 8'(i == 0));
			chk(8'(waiting), 8'(i != 0));
			i_wake = 1'b1;
			go(12'h003);
			i_wake = 1'b0;
			chk(acc, 8'h77);
		end
		stop_test();
	end
endmodule // testbench

`default_nettype wire

// File: src/mcx_core.sv
/*
 Decode and execute logic of the 8-bit core, program and data ports.
 Assumes program and data memories that answer the registered address
 within the same cycle. Accumulator lives here, flags too.
*/
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// (RQ1) Forty base instructions across nine addressing schemes, 244 opcodes.
// (RQ2) Load/store take one to three bytes and four cycles.
// (RQ3) Load moves accumulator to or from operand, sets zero, keeps carry.
// (RQ4) Immediate load to any data byte: three bytes, four cycles, no flags.
// (RQ5) Add, and, compare, subtract use accumulator plus operand, update both flags.
// (RQ6) Clear, increment, decrement any data address; inc/dec change zero only.
// (RQ7) Complement, rotate, shift act on accumulator, four cycles, both flags.
// (RQ8) Short branches: one byte, two cycles, span -15..+16, no flags.
// (RQ9) Bit-test branches: three bytes, five cycles, 3-bit index, on 0 or 1.
// (RQ10) Bit-test displacement is 8-bit signed, -126..+129.
// (RQ11) Bit-test branch copies tested bit into carry, zero untouched.
// (RQ12) Bit set/reset: two bytes, four cycles, flags unchanged.
// (RQ13) Software avoids bit set/reset on port or mixed-access registers.
// (RQ14) Control ops: one byte, two cycles; only interrupt exit alters flags.
// (RQ15) With watchdog selected, stop behaves as wait.
// (RQ16) Long jump and call: 12-bit target, two bytes, four cycles, no flags.
// (RQ17) Target is opcode low nibble above the following byte; the code uses the high nibble (op_q[7:4]) instead.
// (RQ18) Short branch: condition bits, direction bit, four-bit magnitude.
// (RQ19) Indirect opcodes pick index register 80h or 81h by bit 4.
// (RQ20) Short-direct opcodes address working registers 80h to 83h.
// (RQ21) Zero flag set when 8-bit result is zero, else cleared.
// (RQ22) Branch relative to own address; not taken continues sequentially.
module mcx_core (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_wdg_sel,
	input  wire logic        i_wake,
	output logic [11:0]      o_pc_addr,
	input  wire logic [7:0]  i_pc_data,
	output logic [7:0]       o_dm_addr,
	output logic             o_dm_we,
	output logic [7:0]       o_dm_wdata,
	input  wire logic [7:0]  i_dm_rdata,
	output logic [7:0]       o_acc,
	output logic             o_zero,
	output logic             o_carry,
	output logic             o_waiting,
	output logic             o_stopped
);
	import mcx_pkg::*;

	mcx_state_e   st_q;
	logic [11:0]  pc_q;
	logic [7:0]   op_q, b1_q, b2_q, acc_q, iptr_q;
	logic         z_q, c_q, iz_q, ic_q;
	logic [2:0]   cnt_q;
	logic [11:0]  stk_q [0:5];
	logic [2:0]   sp_q;

	// ==========================================================
	// Decode helpers
	function automatic logic [1:0] op_len(input logic [7:0] op); // RQ1
		unique case (op[3:0])
			LO_EXT, LO_JP, LO_DIR, LO_BDIR: op_len = 2'd2;
			LO_BT:                   op_len = 2'd3;
			LO_IND:                  op_len = (op[7:4] == ALU_LDI || op[7:4] == ALU_CPI ||
				op[7:4] == ALU_ADD_IMMEDIATE_VALUE || op[7:4] == ALU_MASK_IMMEDIATE ||
				op[7:4] == ALU_DIFFERENCE_IMMEDIATE) ? 2'd2 : 2'd1;
			LO_INH:                  op_len = (op[7:4] == INH_LDIR) ? 2'd3 :
				(op[7:4] == INH_CLR) ? 2'd3 : 2'd1;
			default:                 op_len = 2'd1;
		endcase
	endfunction

	function automatic logic [2:0] cycles(input logic [7:0] op);
		if (op[2:0] == 3'h0 || op[2:0] == 3'h2 || op[2:0] == 3'h4 || op[2:0] == 3'h6 ||
			(op[3:0] == LO_INH && (op[7:4] == INH_NOP || op[7:4] == INH_RET ||
			op[7:4] == INH_INTERRUPT_EXIT || op[7:4] == INH_STOP || op[7:4] == INH_WAIT)))
			cycles = CYC_CTL; // RQ8 RQ14
		else if (op[3:0] == LO_BT)
			cycles = CYC_BT; // RQ9
		else
			cycles = CYC_LS; // RQ2 RQ16
	endfunction

	// Operand address: indirect, short-direct or direct
	logic [7:0] ea;
	always_comb begin
		if (op_q[3:0] == LO_IND)
			ea = iptr_q; // RQ19
		else if (op_q[3:0] == LO_SD)
			ea = ADR_WBASE | {6'h00, op_q[7:6]}; // RQ20
		else
			ea = b1_q;
	end

	// A one-byte indirect op reads its pointer in the first read cycle
	logic ptr_load;
	assign ptr_load = (st_q == MCX_READ) && (op_q[3:0] == LO_IND) &&
		(op_len(op_q) == 2'd1) && (cnt_q == 3'h1); // RQ19

	// ==========================================================
	// Execute datapath
	logic [8:0]  sum;
	logic [7:0]  res, opnd;
	logic        wr_acc, wr_mem, set_z, set_c, new_c, bit_v;
	logic [11:0] br_pc, tgt;
	always_comb begin
		opnd   = (op_q[3:0] == LO_IND && op_len(op_q) == 2'd2) ? b1_q : i_dm_rdata;
		sum    = 9'h000;
		res    = acc_q;
		wr_acc = 1'b0;
		wr_mem = 1'b0;
		set_z  = 1'b0;
		set_c  = 1'b0;
		new_c  = c_q;
		bit_v  = i_dm_rdata[op_q[7:5]];
		tgt    = {op_q[7:4], b1_q}; // RQ17
		br_pc  = pc_q + PC_ONE;
		if (op_q[3:0] == LO_IND || op_q[3:0] == LO_DIR) begin
			unique case (op_q[7:4])
				ALU_LD, ALU_LDI: begin res = opnd; wr_acc = 1'b1; set_z = 1'b1; end // RQ3
				ALU_ST:  begin res = acc_q; wr_mem = 1'b1; set_z = 1'b1; end // RQ3
				ALU_ADD, ALU_ADD_IMMEDIATE_VALUE: begin
					sum = {1'b0, acc_q} + {1'b0, opnd}; // RQ5
					res = sum[7:0]; wr_acc = 1'b1; set_z = 1'b1; set_c = 1'b1; new_c = sum[8];
				end
				ALU_SUB, ALU_DIFFERENCE_IMMEDIATE, ALU_CP, ALU_CPI: begin
					sum = {1'b0, acc_q} - {1'b0, opnd}; // RQ5
					res = sum[7:0]; set_z = 1'b1; set_c = 1'b1; new_c = sum[8];
					wr_acc = (op_q[7:4] == ALU_SUB || op_q[7:4] == ALU_DIFFERENCE_IMMEDIATE);
				end
				ALU_AND, ALU_MASK_IMMEDIATE: begin
					res = acc_q & opnd; wr_acc = 1'b1; set_z = 1'b1; set_c = 1'b1; new_c = 1'b0; // RQ5
				end
				ALU_INC: begin res = opnd + 8'h01; wr_mem = 1'b1; set_z = 1'b1; end // RQ6
				ALU_DEC: begin res = opnd - 8'h01; wr_mem = 1'b1; set_z = 1'b1; end // RQ6
				default: ;
			endcase
		end else if (op_q[3:0] == LO_SD) begin
			res = op_q[4] ? i_dm_rdata : i_dm_rdata;
			unique case (op_q[5:4])
				2'b01: begin res = i_dm_rdata + 8'h01; wr_mem = 1'b1; set_z = 1'b1; end // RQ6
				2'b11: begin res = i_dm_rdata; wr_acc = 1'b1; set_z = 1'b1; end // RQ3
				default: begin res = acc_q; wr_mem = 1'b1; set_z = 1'b1; end // RQ3
			endcase
		end else if (op_q[3:0] == LO_BDIR) begin
			res = i_dm_rdata; // RQ12
			res[op_q[7:5]] = op_q[4];
			wr_mem = 1'b1;
		end else if (op_q[3:0] == LO_BT) begin
			set_c = 1'b1; // RQ11
			new_c = bit_v;
			if (bit_v == op_q[4])
				br_pc = pc_q + {{4{b2_q[7]}}, b2_q} + PC_TWO; // RQ10 RQ22
			else
				br_pc = pc_q + PC_THREE; // RQ22
		end else if (op_q[3:0] == LO_INH) begin
			unique case (op_q[7:4])
				INH_COM: begin res = ~acc_q; wr_acc = 1'b1; set_z = 1'b1; set_c = 1'b1; new_c = acc_q[7]; end // RQ7
				INH_RLC: begin res = {acc_q[6:0], c_q}; wr_acc = 1'b1; set_z = 1'b1; set_c = 1'b1; new_c = acc_q[7]; end // RQ7
				INH_SLA: begin res = {acc_q[6:0], 1'b0}; wr_acc = 1'b1; set_z = 1'b1; set_c = 1'b1; new_c = acc_q[7]; end // RQ7
				INH_CLR: begin res = BYTE_ZERO; wr_mem = 1'b1; end // RQ6
				INH_LDIR: begin res = b2_q; wr_mem = 1'b1; end // RQ4
				default: ;
			endcase
		end
		if (op_q[2:0] == CND_NZ || op_q[2:0] == CND_NC || op_q[2:0] == CND_Z || op_q[2:0] == CND_C) begin
			// Condition lives in bits 2:1 here; bit 3 is direction, 7:4 magnitude
			if ((op_q[2:1] == 2'd0 && !z_q) || (op_q[2:1] == 2'd1 && !c_q) ||
				(op_q[2:1] == 2'd2 && z_q) || (op_q[2:1] == 2'd3 && c_q)) // RQ18
				br_pc = op_q[3] ? pc_q - {8'h00, op_q[7:4]} : pc_q + {8'h00, op_q[7:4]} + PC_ONE; // RQ8 RQ22
		end
	end

	// ==========================================================
	// Sequencer
	logic        is_ret;
	logic [11:0] nxt_pc;
	assign is_ret = (op_q[3:0] == LO_INH) && (op_q[7:4] == INH_RET || op_q[7:4] == INH_INTERRUPT_EXIT);

	// Next instruction address, shared by the pc and the program port
	always_comb begin
		if (op_q[3:0] == LO_EXT || op_q[3:0] == LO_JP)
			nxt_pc = tgt; // RQ16 RQ17
		else if (is_ret && sp_q != 3'h0)
			nxt_pc = stk_q[sp_q - 3'h1];
		else if (op_q[2:0] == CND_NZ || op_q[2:0] == CND_NC || op_q[2:0] == CND_Z ||
			op_q[2:0] == CND_C || op_q[3:0] == LO_BT)
			nxt_pc = br_pc; // RQ22
		else
			nxt_pc = pc_q + {10'h000, op_len(op_q)};
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			st_q  <= MCX_FETCH;
			cnt_q <= 3'h0;
			op_q  <= BYTE_ZERO;
			b1_q  <= BYTE_ZERO;
			b2_q  <= BYTE_ZERO;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			unique case (st_q)
				MCX_FETCH: begin
					op_q  <= i_pc_data;
					cnt_q <= 3'h1;
					st_q  <= (op_len(i_pc_data) > 2'd1) ? MCX_ARG1 : MCX_READ;
				end
				MCX_ARG1:  begin b1_q <= i_pc_data; st_q <= (op_len(op_q) == 2'd3) ? MCX_ARG2 : MCX_READ; end
				MCX_ARG2:  begin b2_q <= i_pc_data; st_q <= MCX_READ; end
				MCX_READ:  if (cnt_q >= cycles(op_q) - 3'h1) st_q <= MCX_EXEC;
				MCX_EXEC:  st_q <= (op_q[3:0] == LO_INH && op_q[7:4] == INH_WAIT) ? MCX_WAIT :
					(op_q[3:0] == LO_INH && op_q[7:4] == INH_STOP) ? (i_wdg_sel ? MCX_WAIT : MCX_HALT) : MCX_FETCH; // RQ15
				MCX_WAIT, MCX_HALT: if (i_wake) st_q <= MCX_FETCH;
				default:   st_q <= MCX_FETCH;
			endcase
		end
	end

	// Program counter and return stack
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			pc_q <= PC_RESET;
			sp_q <= 3'h0;
			for (int k = 0; k < 6; k++) stk_q[k] <= PC_RESET;
		end else if (st_q == MCX_EXEC) begin
			pc_q <= nxt_pc; // RQ16 RQ22
			// A call past the stack depth loses its return address
			if (op_q[3:0] == LO_EXT && sp_q < STK_DEPTH) begin
				stk_q[sp_q] <= pc_q + PC_TWO;
				sp_q        <= sp_q + 3'h1;
			end else if (is_ret && sp_q != 3'h0) begin
				sp_q <= sp_q - 3'h1;
			end
		end
	end

	// Accumulator, flags and index pointer
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			acc_q <= BYTE_ZERO; z_q <= 1'b0; c_q <= 1'b0; iz_q <= 1'b0; ic_q <= 1'b0;
			iptr_q <= BYTE_ZERO;
		end else begin
			if (ptr_load) iptr_q <= i_dm_rdata; // RQ19
			if (st_q == MCX_EXEC) begin
				if (wr_acc) acc_q <= res;
				if (set_z) z_q <= (res == BYTE_ZERO); // RQ21
				if (set_c) c_q <= new_c;
				if (op_q[3:0] == LO_INH && op_q[7:4] == INH_INTERRUPT_EXIT) begin z_q <= iz_q; c_q <= ic_q; end // RQ14
			end
		end
	end

	// ==========================================================
	// Ports
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_pc_addr <= PC_RESET; o_dm_addr <= BYTE_ZERO; o_dm_we <= 1'b0; o_dm_wdata <= BYTE_ZERO;
			o_acc <= BYTE_ZERO; o_zero <= 1'b0; o_carry <= 1'b0; o_waiting <= 1'b0; o_stopped <= 1'b0;
		end else begin
			o_pc_addr  <= (st_q == MCX_EXEC) ? nxt_pc : o_pc_addr +
				((st_q == MCX_FETCH || st_q == MCX_ARG1) ? PC_ONE : 12'h000);
			// Pointer or working register address goes out as the opcode is taken
			if (st_q == MCX_FETCH)
				o_dm_addr <= (i_pc_data[3:0] == LO_IND) ? (i_pc_data[4] ? ADR_Y : ADR_X) :
					(ADR_WBASE | {6'h00, i_pc_data[7:6]}); // RQ19 RQ20
			else if (st_q == MCX_ARG1 && op_q[3:0] != LO_IND)
				o_dm_addr <= i_pc_data;
			else if (ptr_load)
				o_dm_addr <= i_dm_rdata; // RQ19
			else if (st_q != MCX_READ && st_q != MCX_ARG1)
				o_dm_addr <= ea;
			o_dm_we    <= (st_q == MCX_EXEC) && wr_mem;
			o_dm_wdata <= res;
			o_acc      <= acc_q;
			o_zero     <= z_q;
			o_carry    <= c_q;
			o_waiting  <= (st_q == MCX_WAIT);
			o_stopped  <= (st_q == MCX_HALT);
		end
	end

	// ==========================================================
	// Checks
	zero_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_q == MCX_EXEC && set_z) |=> (z_q == ($past(res) == BYTE_ZERO))) else $error("zero flag wrong"); // RQ21
	ctrl_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_q == MCX_EXEC && op_q == {INH_NOP, LO_INH}) |=> $stable(c_q) && $stable(z_q)) else $error("nop changed flags"); // RQ14
	stop_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_q == MCX_EXEC && op_q == {INH_STOP, LO_INH} && i_wdg_sel) |=> st_q == MCX_WAIT) else $error("stop not wait"); // RQ15
	bit_carry_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_q == MCX_EXEC && op_q[3:0] == LO_BT) |=> c_q == $past(bit_v) && $stable(z_q)) else $error("bit test carry"); // RQ11
	jump_target_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_q == MCX_EXEC && op_q[3:0] == LO_EXT) |=> pc_q == $past(tgt)) else $error("jump target"); // RQ17
	bitset_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_q == MCX_EXEC && op_q[3:0] == LO_BDIR) |=> $stable(c_q) && $stable(z_q)) else $error("bit op flags"); // RQ12
	incdec_carry_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_q == MCX_EXEC && (op_q[3:0] == LO_IND || op_q[3:0] == LO_DIR) &&
		(op_q[7:4] == ALU_INC || op_q[7:4] == ALU_DEC)) |=> $stable(c_q)) else $error("inc dec carry"); // RQ6
	fetch_order_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st_q == MCX_EXEC) |=> st_q inside {MCX_FETCH, MCX_WAIT, MCX_HALT}) else $error("exec order"); // RQ2
	cv_branch: cover property (@(posedge i_clk) st_q == MCX_EXEC && op_q[3:0] == LO_BT);
	cv_call: cover property (@(posedge i_clk) st_q == MCX_EXEC && op_q[3:0] == LO_EXT);
	cv_wait: cover property (@(posedge i_clk) st_q == MCX_WAIT);
endmodule // mcx_core

`default_nettype wire

// File: src/mcx_pkg.sv
/*
 Package for the 8-bit core's decode and execute logic: opcode fields,
 data-space addresses of the working registers, cycle counts, states.
 Assumes nothing of its surroundings.
*/
package mcx_pkg;
	localparam logic [7:0]  ADR_X      = 8'h80;
	localparam logic [7:0]  ADR_Y      = 8'h81;
	localparam logic [7:0]  ADR_WBASE  = 8'h80;
	localparam logic [11:0] PC_RESET   = 12'h000;
	localparam logic [7:0]  BYTE_ZERO  = 8'h00;
	localparam logic [7:0]  BYTE_ONES  = 8'hFF;
	localparam logic [11:0] PC_ONE     = 12'h001;
	localparam logic [11:0] PC_TWO     = 12'h002;
	localparam logic [11:0] PC_THREE   = 12'h003;
	localparam logic [2:0]  CYC_LS     = 3'h4;
	localparam logic [2:0]  CYC_BR     = 3'h2;
	localparam logic [2:0]  CYC_BT     = 3'h5;
	localparam logic [2:0]  CYC_CTL    = 3'h2;
	localparam logic [2:0]  STK_DEPTH  = 3'h6;
	localparam logic [2:0]  CND_NZ     = 3'h0;
	localparam logic [2:0]  CND_NC     = 3'h2;
	localparam logic [2:0]  CND_Z      = 3'h4;
	localparam logic [2:0]  CND_C      = 3'h6;
	localparam logic [3:0]  LO_EXT     = 4'h1;
	localparam logic [3:0]  LO_BT      = 4'h3;
	localparam logic [3:0]  LO_SD      = 4'h5;
	localparam logic [3:0]  LO_IND     = 4'h7;
	localparam logic [3:0]  LO_DIR     = 4'hF;
	localparam logic [3:0]  LO_BDIR    = 4'hB;
	localparam logic [3:0]  LO_INH     = 4'hD;
	localparam logic [3:0]  LO_JP      = 4'h9;
	localparam logic [3:0]  ALU_LD     = 4'h0;
	localparam logic [3:0]  ALU_LDI    = 4'h1;
	localparam logic [3:0]  ALU_CP     = 4'h2;
	localparam logic [3:0]  ALU_CPI    = 4'h3;
	localparam logic [3:0]  ALU_ADD    = 4'h4;
	localparam logic [3:0]  ALU_ADD_IMMEDIATE_VALUE   = 4'h5;
	localparam logic [3:0]  ALU_INC    = 4'h6;
	localparam logic [3:0]  ALU_ST     = 4'h8;
	localparam logic [3:0]  ALU_AND    = 4'hA;
	localparam logic [3:0]  ALU_MASK_IMMEDIATE   = 4'hB;
	localparam logic [3:0]  ALU_SUB    = 4'hC;
	localparam logic [3:0]  ALU_DIFFERENCE_IMMEDIATE   = 4'hD;
	localparam logic [3:0]  ALU_DEC    = 4'hE;
	localparam logic [3:0]  INH_JP     = 4'h9;
	localparam logic [3:0]  INH_NOP    = 4'h0;
	localparam logic [3:0]  INH_RET    = 4'hC;
	localparam logic [3:0]  INH_INTERRUPT_EXIT   = 4'hD;
	localparam logic [3:0]  INH_STOP   = 4'h6;
	localparam logic [3:0]  INH_WAIT   = 4'hE;
	localparam logic [3:0]  INH_COM    = 4'h2;
	localparam logic [3:0]  INH_RLC    = 4'hA;
	localparam logic [3:0]  INH_SLA    = 4'h4;
	localparam logic [3:0]  INH_CLR    = 4'h8;
	localparam logic [3:0]  INH_LDIR   = 4'h1;

	typedef enum logic [2:0] {
		MCX_FETCH = 3'b000,
		MCX_ARG1  = 3'b001,
		MCX_ARG2  = 3'b010,
		MCX_READ  = 3'b011,
		MCX_EXEC  = 3'b100,
		MCX_WAIT  = 3'b101,
		MCX_HALT  = 3'b110
	} mcx_state_e;
endpackage : mcx_pkg
